// ==== cpd_pkg.sv ====
// Constants, types and register map for the coprocessor instruction decoder.
// Assumes a 32-bit core bus and an AXI4-Lite register port with 8-bit addresses.
package cpd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int CPD_ADDR_W = 8;
  localparam logic [7:0] CPD_CTRL_OFS = 8'h00;
  localparam logic [7:0] CPD_STATUS_OFS = 8'h04;
  localparam logic [7:0] CPD_MASK_OFS = 8'h08;
  localparam logic [7:0] CPD_LAST_INSTR_OFS = 8'h0c;
  localparam logic [7:0] CPD_LAST_ADDR_OFS = 8'h10;
  localparam logic [7:0] CPD_TRAP_CNT_OFS = 8'h14;
  localparam int CPD_CTRL_W = 8;
  localparam int CPD_STATUS_W = 3;
  localparam logic [7:0] CPD_CTRL_RST = 8'h00;
  localparam logic [2:0] CPD_MASK_RST = 3'h0;
  localparam logic [2:0] CPD_STATUS_RST = 3'h0;
  localparam int CPD_ST_TRAP = 0;
  localparam int CPD_ST_SKIP = 1;
  localparam int CPD_ST_WB = 2;
  localparam logic [1:0] CPD_RESP_OKAY = 2'h0;
  localparam logic [1:0] CPD_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  localparam int CPD_COND_LO = 28;
  localparam int CPD_CLASS_LO = 24;
  localparam logic [3:0] CPD_DATA_OP_PAT = 4'he;
  localparam int CPD_XFER_LO = 25;
  localparam logic [2:0] CPD_XFER_PAT = 3'h6;
  localparam int CPD_ZERO_BIT = 4;
  localparam int CPD_OPB_LO = 0;
  localparam int CPD_INFO_LO = 5;
  localparam int CPD_NUM_LO = 8;
  localparam int CPD_DEST_LO = 12;
  localparam int CPD_OPA_LO = 16;
  localparam int CPD_OPC_LO = 20;
  localparam int CPD_OFS_LO = 0;
  localparam int CPD_LOAD_BIT = 20;
  localparam int CPD_WB_BIT = 21;
  localparam int CPD_LEN_BIT = 22;
  localparam int CPD_UP_BIT = 23;
  localparam int CPD_PRE_BIT = 24;
  localparam int CPD_OFS_SHIFT = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CPD_CLK_PERIOD_NS = 100;
  localparam int CPD_SEQ_CYCLES = 1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic is_data_op;
    logic is_xfer;
    logic is_load;
    logic long_sel;
    logic wb;
    logic up;
    logic pre;
    logic [3:0] coproc_opcode_field;
    logic [2:0] coproc_info_field;
    logic [3:0] coproc_operand_a_reg;
    logic [3:0] coproc_operand_b_reg;
    logic [3:0] coproc_dest_reg;
    logic [3:0] coproc_number_field;
    logic [3:0] base_reg_index;
    logic [7:0] offset;
  } cpd_decode_t;

  typedef enum logic [2:0] {
    CPD_IDLE = 3'b001,
    CPD_EXEC = 3'b010,
    CPD_BUSY = 3'b100
  } cpd_state_t;

endpackage : cpd_pkg

// ==== cpd_cond.sv ====
// Condition field evaluator for the coprocessor decoder.
// Assumes flags arrive as {N, Z, C, V} from the core on the same clock.
`timescale 1ns/1ps
module cpd_cond (
  input wire logic [3:0] cond,
  input wire logic [3:0] flags,
  output logic pass
);
  logic n;
  logic z;
  logic c;
  logic v;

  always_comb begin
    n = flags[3];
    z = flags[2];
    c = flags[1];
    v = flags[0];
    unique case (cond)
      4'h0: pass = z;
      4'h1: pass = !z;
      4'h2: pass = c;
      4'h3: pass = !c;
      4'h4: pass = n;
      4'h5: pass = !n;
      4'h6: pass = v;
      4'h7: pass = !v;
      4'h8: pass = c && !z;
      4'h9: pass = !c || z;
      4'ha: pass = n == v;
      4'hb: pass = n != v;
      4'hc: pass = !z && (n == v);
      4'hd: pass = z || (n != v);
      4'he: pass = 1'b1;
      // Never-execute code
      4'hf: pass = 1'b0;
    endcase
  end
endmodule : cpd_cond

// ==== cpd_decode.sv ====
// Coprocessor data operation and data transfer decoder with AXI4-Lite registers.
// Assumes instructions and flags come from core logic on aclk; no coprocessor exists.
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps

// Function
// RULE1: Instruction acts only when its condition field evaluates true.
// RULE2: Data operation returns no result and never waits for one.
// RULE3: Every passing coprocessor instruction raises the undefined-instruction trap.
// RULE4: Data operation fields at fixed positions, bit 4 zero, pattern 1110.
// RULE5: Core recognises data operations from bit 4 and bits 24-31 only.
// RULE6: Coprocessor numbered 0-15 ignores instructions carrying another number.
// RULE7: Coprocessor conventionally applies opcode to operands, writes destination.
// RULE8: Data operation takes one sequential cycle plus busy-wait cycles.
// RULE9: Core generates transfer addresses; coprocessor supplies or takes data.
// RULE10: Coprocessor decides how many words a transfer moves.
// RULE11: Transfer holds offset, number, coprocessor and base register fields.
// RULE12: Bit 20 selects store (0) or load (1).
// RULE13: Bit 21 set writes the computed address back to the base.
// RULE14: Bit 22 length selector passes through uninterpreted.
// RULE15: Offset shifted left two, added when bit 23 set, else subtracted.
// RULE16: Bit 24 set applies offset before transfer, clear applies it after.
module cpd_decode (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cpd_pkg::CPD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cpd_pkg::CPD_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [31:0] instr_word,
  input wire logic [3:0] cond_flags,
  input wire logic [31:0] base_value,
  output logic op_done,
  output logic trap_req,
  output cpd_pkg::cpd_decode_t decoded,
  output logic [31:0] mem_addr,
  output logic base_wb_en,
  output logic [31:0] base_wb_value,
  output logic irq
);

  // ----------------------------------------------------------------
  // Instruction sequencing
  // ----------------------------------------------------------------
  cpd_pkg::cpd_state_t state_q, state_d;
  logic [31:0] instr_q, instr_d;
  logic [31:0] base_q, base_d;
  logic pass_q, pass_d;
  logic [7:0] busy_q, busy_d;
  logic ready_d, done_d, trap_d, wb_en_d;
  cpd_pkg::cpd_decode_t dec_d, dec_w;
  logic [31:0] addr_d, wbval_d;
  logic cond_pass, acc, finish, is_cp_q;
  logic [31:0] ofs_w, mod_w;
  logic [2:0] status_set;
  logic [cpd_pkg::CPD_CTRL_W-1:0] ctrl_q, ctrl_d;

  cpd_cond u_cond (
    .cond(instr_word[cpd_pkg::CPD_COND_LO +: 4]),
    .flags(cond_flags),
    .pass(cond_pass)
  );

  assign acc = instr_valid && instr_ready;

  always_comb begin
    // Core looks only at class bits and bit 4 for data operations [RULE5]
    dec_w = '0;
    dec_w.is_data_op = (instr_q[cpd_pkg::CPD_CLASS_LO +: 4] == cpd_pkg::CPD_DATA_OP_PAT)
        && !instr_q[cpd_pkg::CPD_ZERO_BIT]; // [RULE5] [RULE4]
    dec_w.is_xfer = instr_q[cpd_pkg::CPD_XFER_LO +: 3] == cpd_pkg::CPD_XFER_PAT;
    dec_w.coproc_opcode_field = instr_q[cpd_pkg::CPD_OPC_LO +: 4]; // [RULE4]
    dec_w.coproc_info_field = instr_q[cpd_pkg::CPD_INFO_LO +: 3]; // [RULE4]
    dec_w.coproc_operand_a_reg = instr_q[cpd_pkg::CPD_OPA_LO +: 4]; // [RULE4]
    dec_w.coproc_operand_b_reg = instr_q[cpd_pkg::CPD_OPB_LO +: 4]; // [RULE4]
    dec_w.coproc_dest_reg = instr_q[cpd_pkg::CPD_DEST_LO +: 4]; // [RULE4] [RULE11]
    dec_w.coproc_number_field = instr_q[cpd_pkg::CPD_NUM_LO +: 4]; // [RULE4] [RULE11]
    dec_w.base_reg_index = instr_q[cpd_pkg::CPD_OPA_LO +: 4]; // [RULE11]
    dec_w.offset = instr_q[cpd_pkg::CPD_OFS_LO +: 8]; // [RULE11]
    dec_w.is_load = instr_q[cpd_pkg::CPD_LOAD_BIT]; // [RULE12]
    dec_w.wb = instr_q[cpd_pkg::CPD_WB_BIT]; // [RULE13]
    dec_w.long_sel = instr_q[cpd_pkg::CPD_LEN_BIT]; // [RULE14]
    dec_w.up = instr_q[cpd_pkg::CPD_UP_BIT];
    dec_w.pre = instr_q[cpd_pkg::CPD_PRE_BIT];
    is_cp_q = dec_w.is_data_op || dec_w.is_xfer;
    // Word offset scaled to bytes, then added or subtracted [RULE15]
    ofs_w = {24'h0, dec_w.offset} << cpd_pkg::CPD_OFS_SHIFT;
    mod_w = dec_w.up ? base_q + ofs_w : base_q - ofs_w; // [RULE15]
  end

  always_comb begin
    state_d = state_q;
    instr_d = instr_q;
    base_d = base_q;
    pass_d = pass_q;
    busy_d = busy_q;
    ready_d = instr_ready;
    done_d = 1'b0;
    trap_d = 1'b0;
    wb_en_d = 1'b0;
    dec_d = decoded;
    addr_d = mem_addr;
    wbval_d = base_wb_value;
    finish = 1'b0;
    status_set = '0;
    unique case (state_q)
      cpd_pkg::CPD_IDLE: begin
        if (acc) begin
          instr_d = instr_word;
          base_d = base_value;
          pass_d = cond_pass; // [RULE1]
          busy_d = ctrl_q;
          state_d = cpd_pkg::CPD_EXEC;
          ready_d = 1'b0;
        end
      end
      // The single sequential cycle; busy-wait cycles follow [RULE8]
      cpd_pkg::CPD_EXEC: begin
        if (busy_q != 8'h0) begin
          state_d = cpd_pkg::CPD_BUSY;
        end else begin
          finish = 1'b1;
        end
      end
      cpd_pkg::CPD_BUSY: begin
        busy_d = busy_q - 8'h1; // [RULE8]
        if (busy_q == 8'h1) begin
          finish = 1'b1;
        end
      end
      default: begin
        state_d = cpd_pkg::CPD_IDLE;
        ready_d = 1'b1;
      end
    endcase
    // No result is awaited: the core is free again at once [RULE2]
    if (finish) begin
      state_d = cpd_pkg::CPD_IDLE;
      ready_d = 1'b1;
      done_d = 1'b1;
      dec_d = dec_w;
      trap_d = pass_q && is_cp_q; // [RULE3] [RULE1]
      // Only the first word's address; the coprocessor decides how many words follow [RULE9] [RULE16]
      if (dec_w.is_xfer) begin
        addr_d = dec_w.pre ? mod_w : base_q; // [RULE16] [RULE9]
        wbval_d = mod_w;
        wb_en_d = pass_q && dec_w.wb; // [RULE13] [RULE1]
      end
      status_set[cpd_pkg::CPD_ST_TRAP] = trap_d;
      status_set[cpd_pkg::CPD_ST_SKIP] = !pass_q && is_cp_q;
      status_set[cpd_pkg::CPD_ST_WB] = wb_en_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= cpd_pkg::CPD_IDLE;
      instr_q <= 32'h0;
      base_q <= 32'h0;
      pass_q <= 1'b0;
      busy_q <= 8'h0;
      instr_ready <= 1'b1;
      op_done <= 1'b0;
      trap_req <= 1'b0;
      base_wb_en <= 1'b0;
      decoded <= '0;
      mem_addr <= 32'h0;
      base_wb_value <= 32'h0;
    end else begin
      state_q <= state_d;
      instr_q <= instr_d;
      base_q <= base_d;
      pass_q <= pass_d;
      busy_q <= busy_d;
      instr_ready <= ready_d;
      op_done <= done_d;
      trap_req <= trap_d;
      base_wb_en <= wb_en_d;
      decoded <= dec_d;
      mem_addr <= addr_d;
      base_wb_value <= wbval_d;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave, status and interrupt
  // ----------------------------------------------------------------
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [cpd_pkg::CPD_ADDR_W-1:0] awaddr_q, awaddr_d, wr_ofs, rd_ofs;
  logic [31:0] wdata_q, wdata_d, wmerge;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d, irq_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d, trap_cnt_q, trap_cnt_d;
  logic [2:0] status_q, status_d, status_clr, mask_q, mask_d;

  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = s_axi_bvalid;
    bresp_d = s_axi_bresp;
    rvalid_d = s_axi_rvalid;
    rdata_d = s_axi_rdata;
    rresp_d = s_axi_rresp;
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    status_clr = '0;
    wr_ofs = {awaddr_q[cpd_pkg::CPD_ADDR_W-1:2], 2'h0};
    rd_ofs = {s_axi_araddr[cpd_pkg::CPD_ADDR_W-1:2], 2'h0};
    for (int i = 0; i < 4; i++) begin
      wmerge[8*i +: 8] = wstrb_q[i] ? wdata_q[8*i +: 8] : 8'h0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // Address and data may arrive in either order; answer once both are held
    if (aw_full_q && w_full_q && !s_axi_bvalid) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = cpd_pkg::CPD_RESP_OKAY;
      case (wr_ofs)
        cpd_pkg::CPD_CTRL_OFS: begin
          if (wstrb_q[0]) begin
            ctrl_d = wdata_q[cpd_pkg::CPD_CTRL_W-1:0];
          end
        end
        cpd_pkg::CPD_STATUS_OFS: status_clr = wmerge[cpd_pkg::CPD_STATUS_W-1:0];
        cpd_pkg::CPD_MASK_OFS: begin
          if (wstrb_q[0]) begin
            mask_d = wdata_q[cpd_pkg::CPD_STATUS_W-1:0];
          end
        end
        cpd_pkg::CPD_LAST_INSTR_OFS, cpd_pkg::CPD_LAST_ADDR_OFS,
        cpd_pkg::CPD_TRAP_CNT_OFS: bresp_d = cpd_pkg::CPD_RESP_OKAY;
        default: bresp_d = cpd_pkg::CPD_RESP_SLVERR;
      endcase
    end
    awready_d = !aw_full_d;
    wready_d = !w_full_d;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = cpd_pkg::CPD_RESP_OKAY;
      case (rd_ofs)
        cpd_pkg::CPD_CTRL_OFS: rdata_d = {24'h0, ctrl_q};
        cpd_pkg::CPD_STATUS_OFS: rdata_d = {29'h0, status_q};
        cpd_pkg::CPD_MASK_OFS: rdata_d = {29'h0, mask_q};
        cpd_pkg::CPD_LAST_INSTR_OFS: rdata_d = instr_q;
        cpd_pkg::CPD_LAST_ADDR_OFS: rdata_d = mem_addr;
        cpd_pkg::CPD_TRAP_CNT_OFS: rdata_d = trap_cnt_q;
        default: begin
          rdata_d = 32'h0;
          rresp_d = cpd_pkg::CPD_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = !rvalid_d;
    // A new event beats a simultaneous clear
    status_d = (status_q & ~status_clr) | status_set;
    trap_cnt_d = trap_cnt_q + {31'h0, trap_d};
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cpd_pkg::CPD_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= cpd_pkg::CPD_RESP_OKAY;
      ctrl_q <= cpd_pkg::CPD_CTRL_RST;
      mask_q <= cpd_pkg::CPD_MASK_RST;
      status_q <= cpd_pkg::CPD_STATUS_RST;
      trap_cnt_q <= 32'h0;
      irq <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      status_q <= status_d;
      trap_cnt_q <= trap_cnt_d;
      irq <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [8:0] cyc_q;
  logic [7:0] blat_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_q <= 9'h0;
      blat_q <= 8'h0;
    end else if (acc) begin
      cyc_q <= 9'h0;
      blat_q <= ctrl_q;
    end else if (state_q != cpd_pkg::CPD_IDLE) begin
      cyc_q <= cyc_q + 9'h1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence cp_pass_accept_s;
    acc && cond_pass && ((instr_word[27:24] == 4'he && !instr_word[4])
        || instr_word[27:25] == 3'h6);
  endsequence
  sequence short_data_op_s;
    acc && instr_word[27:24] == 4'he && !instr_word[4] && ctrl_q == 8'h0;
  endsequence

  trap_on_pass_a: assert property (cp_pass_accept_s |-> ##[2:258] trap_req) // [RULE3]
    else $error("passing coprocessor instruction raised no trap");
  cond_block_a: assert property (op_done && !pass_q |-> !trap_req && !base_wb_en) // [RULE1]
    else $error("failed condition still had an effect");
  no_stall_a: assert property (short_data_op_s |=> !instr_ready ##1 (instr_ready && op_done)) // [RULE2]
    else $error("data operation stalled the core");
  busy_cycles_a: assert property (op_done |-> cyc_q == {1'b0, blat_q} + 9'h1) // [RULE8]
    else $error("cycle count differs from one plus busy-wait");
  data_fields_a: assert property (op_done && decoded.is_data_op |-> // [RULE4]
      decoded.coproc_opcode_field == instr_q[23:20] && decoded.coproc_info_field == instr_q[7:5]
      && decoded.coproc_number_field == instr_q[11:8] && decoded.coproc_dest_reg == instr_q[15:12]
      && decoded.coproc_operand_a_reg == instr_q[19:16]
      && decoded.coproc_operand_b_reg == instr_q[3:0])
    else $error("data operation field misplaced");
  class_bits_a: assert property (op_done |-> // [RULE5]
      decoded.is_data_op == (instr_q[27:24] == 4'he && !instr_q[4]))
    else $error("data operation class misdecoded");
  xfer_fields_a: assert property (op_done && decoded.is_xfer |-> // [RULE11]
      decoded.offset == instr_q[7:0] && decoded.base_reg_index == instr_q[19:16]
      && decoded.is_load == instr_q[20] && decoded.long_sel == instr_q[22])
    else $error("transfer field misplaced");
  xfer_addr_a: assert property (op_done && decoded.is_xfer |-> mem_addr == (instr_q[24] // [RULE16]
      ? (instr_q[23] ? base_q + {22'h0, instr_q[7:0], 2'h0} : base_q - {22'h0, instr_q[7:0], 2'h0})
      : base_q))
    else $error("transfer address wrong");
  write_back_a: assert property (op_done && decoded.is_xfer && pass_q |-> // [RULE13]
      base_wb_en == instr_q[21] && base_wb_value == (instr_q[23]
      ? base_q + {22'h0, instr_q[7:0], 2'h0} : base_q - {22'h0, instr_q[7:0], 2'h0}))
    else $error("base write-back wrong");

endmodule : cpd_decode

// ==== cpd_trap_model.sv ====
// Trap handler model standing in for the absent coprocessor.
// Assumes the decoder's trap_req pulses and decoded fields on aclk.
`timescale 1ns/1ps
module cpd_trap_model #(
  parameter logic [3:0] OWN_NUM = 4'h3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic trap_req,
  input wire cpd_pkg::cpd_decode_t decoded,
  output int traps_mine,
  output int words_moved,
  output logic [3:0] last_dest
);
  // Emulates only its own number; other numbers belong to other handlers
  always @(posedge aclk) begin
    if (!aresetn) begin
      traps_mine <= 0;
      words_moved <= 0;
      last_dest <= 4'h0;
    end else if (trap_req && decoded.coproc_number_field == OWN_NUM) begin
      traps_mine <= traps_mine + 1;
      if (decoded.is_xfer) begin
        words_moved <= words_moved + (decoded.long_sel ? 2 : 1);
      end else begin
        last_dest <= decoded.coproc_dest_reg;
      end
    end
  end
endmodule : cpd_trap_model

// ==== cpd_decode_tb.sv ====
// Self-checking bench for the coprocessor decoder.
// Assumes the AXI slave answers within 100 cycles.
`timescale 1ns/1ps
module cpd_decode_tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, instr_valid, instr_ready;
  logic op_done, trap_req, base_wb_en, irq, got_trap, got_wb, got_rdy;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, instr_word, base_value, mem_addr, base_wb_value, rd;
  logic [3:0] wstrb, cond_flags, last_dest;
  logic [1:0] bresp, rresp, rs;
  cpd_pkg::cpd_decode_t decoded;
  int n_mismatch = 0;
  int check_count = 0;
  int traps_mine, words_moved, lat;

  cpd_decode i_cpd_decode (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .instr_word(instr_word), .cond_flags(cond_flags), .base_value(base_value),
    .op_done(op_done), .trap_req(trap_req), .decoded(decoded), .mem_addr(mem_addr),
    .base_wb_en(base_wb_en), .base_wb_value(base_wb_value), .irq(irq));

  cpd_trap_model i_cpd_trap_model (.aclk(aclk), .aresetn(aresetn), .trap_req(trap_req),
    .decoded(decoded), .traps_mine(traps_mine), .words_moved(words_moved),
    .last_dest(last_dest));

  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tmo(input string what);
    n_mismatch++;
    $display("[ERR] %0t timeout %s", $time, what);
    test_done();
  endtask : tmo

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 100) tmo("write");
    rs = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 100) tmo("read");
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Latency counts sampled edges from the taking edge to op_done
  task automatic issue(input logic [31:0] w, input logic [3:0] f, input logic [31:0] b);
    int n;
    @(posedge aclk);
    instr_word <= w;
    cond_flags <= f;
    base_value <= b;
    instr_valid <= 1'b1;
    for (n = 0; n < 300; n++) begin
      @(posedge aclk);
      if (instr_ready === 1'b1) break;
    end
    if (n == 300) tmo("take");
    instr_valid <= 1'b0;
    for (lat = 1; lat < 300; lat++) begin
      @(posedge aclk);
      if (op_done === 1'b1) break;
    end
    if (lat == 300) tmo("done");
    got_trap = trap_req;
    got_wb = base_wb_en;
    got_rdy = instr_ready;
  endtask : issue

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_data_op();
    issue(32'hee521343, 4'h0, 32'h0);
    chk(lat, 2, "latency");
    chk(got_trap, 1, "trap");
    chk({got_wb, got_rdy}, 2'b01, "no wait");
    chk(decoded.is_data_op, 1, "class");
    chk({decoded.coproc_opcode_field, decoded.coproc_operand_a_reg, decoded.coproc_dest_reg,
      decoded.coproc_number_field, decoded.coproc_info_field, decoded.coproc_operand_b_reg},
      {4'h5, 4'h2, 4'h1, 4'h3, 3'h2, 4'h3}, "fields");
    $display("t_data_op done");
  endtask : t_data_op

  task automatic t_cond();
    issue(32'h0e521343, 4'h0, 32'h0);
    chk(got_trap, 0, "cond fail");
    issue(32'h0e521543, 4'h4, 32'h0);
    chk(got_trap, 1, "cond pass");
    issue(32'hee521353, 4'h0, 32'h0);
    chk(got_trap, 0, "bit4 set");
    $display("t_cond done");
  endtask : t_cond

  task automatic t_xfer();
    issue(32'hedf47310, 4'h0, 32'h1000);
    chk(got_trap, 1, "xfer trap");
    chk(mem_addr, 32'h1040, "pre up addr");
    chk({got_wb, base_wb_value}, {1'b1, 32'h1040}, "wb");
    chk({decoded.is_xfer, decoded.is_load, decoded.long_sel, decoded.up, decoded.pre,
      decoded.wb}, 6'h3f, "flags set");
    chk({decoded.base_reg_index, decoded.coproc_dest_reg, decoded.coproc_number_field,
      decoded.offset}, 20'h47310, "fields");
    issue(32'hec047310, 4'h0, 32'h1000);
    chk(mem_addr, 32'h1000, "post addr");
    chk(base_wb_value, 32'h0fc0, "down value");
    chk(got_wb, 0, "no wb");
    chk({decoded.is_xfer, decoded.is_load, decoded.long_sel, decoded.up, decoded.pre,
      decoded.wb}, 6'h20, "flags clear");
    $display("t_xfer done");
  endtask : t_xfer

  task automatic t_busy();
    axi_wr(cpd_pkg::CPD_CTRL_OFS, 32'h3);
    chk(rs, cpd_pkg::CPD_RESP_OKAY, "ctrl resp");
    issue(32'hee521343, 4'h0, 32'h0);
    chk(lat, 5, "busy latency");
    axi_wr(cpd_pkg::CPD_CTRL_OFS, 32'h0);
    $display("t_busy done");
  endtask : t_busy

  task automatic t_regs();
    chk(irq, 0, "irq masked");
    axi_rd(cpd_pkg::CPD_STATUS_OFS);
    chk(rd, 32'h7, "status");
    axi_wr(cpd_pkg::CPD_MASK_OFS, 32'h1);
    repeat (3) @(posedge aclk);
    chk(irq, 1, "irq raised");
    axi_wr(cpd_pkg::CPD_STATUS_OFS, 32'h1);
    repeat (3) @(posedge aclk);
    chk(irq, 0, "irq cleared");
    axi_rd(cpd_pkg::CPD_STATUS_OFS);
    chk(rd, 32'h6, "w1c");
    axi_wr(cpd_pkg::CPD_TRAP_CNT_OFS, 32'h0);
    axi_rd(cpd_pkg::CPD_TRAP_CNT_OFS);
    chk(rd, 32'h5, "trap count");
    axi_rd(8'h40);
    chk(rs, cpd_pkg::CPD_RESP_SLVERR, "unmapped read");
    axi_wr(8'h40, 32'h1);
    chk(rs, cpd_pkg::CPD_RESP_SLVERR, "unmapped write");
    chk(traps_mine, 4, "model traps");
    chk(words_moved, 3, "model words");
    chk(last_dest, 4'h1, "dest");
    $display("t_regs done");
  endtask : t_regs

  initial begin
    aclk = 1'b0;
    forever #(cpd_pkg::CPD_CLK_PERIOD_NS / 2) aclk = ~aclk;
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, instr_valid} = 6'h0;
    {awaddr, araddr} = 16'h0;
    {wdata, instr_word, base_value} = 96'h0;
    wstrb = 4'hf;
    cond_flags = 4'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_data_op();
    t_cond();
    t_xfer();
    t_busy();
    t_regs();
    test_done();
  end
endmodule : cpd_decode_tb
